// file: rtl/inb_regs.svh
`ifndef INB_REGS_SVH
`define INB_REGS_SVH
// Spectrum geometry: 8 slices over the full span
`define INB_SLICES 4'h8
`define INB_SLICE_W 3
`define INB_BIN_W 16
// Settings
`define INB_SENS_MAX 4'hF
`define INB_DUR_MAX_MS 7'h63
// Clock 250 MHz, 1 ms tick
`define INB_CLK_MHZ 250
`define INB_MS_NS 1000000
`define INB_CLK_NS 4
`define INB_MS_CYCLES (`INB_MS_NS / `INB_CLK_NS)
// Marker word sent in place of spectrum data
`define INB_MARK_CODE 16'hFFFF
`define INB_FIFO_DEPTH 4
`endif

// file: rtl/inb_pkg.sv
package inb_pkg;
  typedef enum logic [2:0] {
    INB_DOUBLE_SIDEBAND, INB_SIDEBAND_MORSE, INB_EXT_UPPER_SIDEBAND, INB_CW, INB_ENV_AM,
    INB_NFM, INB_WFM, INB_OTHER
  } inb_demod_e;
  typedef enum logic [1:0] {INB_IDLE, INB_SUBST, INB_CLEAN_WAIT} inb_state_e;
endpackage

// file: rtl/inb_fifo.sv
`timescale 1ns/10ps
module inb_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } inb_fifo_s;
  inb_fifo_s st;
  inb_fifo_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_o = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st.cnt != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[st.rp];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wp] <= in_data_i;
    end
  end
endmodule

// file: rtl/inb_blanker.sv
`timescale 1ns/10ps
`include "inb_regs.svh"
// How it works
// - The frame arrives as eight slices, each summed to a level separately.
// - Detection looks at the slice with the lowest level this frame, and counts rises in all eight slices.
// - A glitch is a fast rise of that quiet slice plus broadband response in most slices.
// - A glitch frame is sent with every word replaced by the marker code.
// - Clean data is never scaled or muted, only replaced.
// - Sensitivity 0..15 sets threshold and slew; higher is more sensitive, 0 disables.
// - Blanking-active output is high while substitution runs.
// - Substitution lasts the set number of ms, clamped to 99.
// - After a substitution at least one real spectrum passes before the next.
// - Envelope AM and both FM demodulators never start substitution; one already running continues.
module inb_blanker (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] sens_i,
  input wire logic [6:0] dur_ms_i,
  input wire inb_pkg::inb_demod_e demod_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [`INB_BIN_W-1:0] in_bin_i,
  input wire logic in_sof_i,
  input wire logic [`INB_SLICE_W-1:0] in_slice_i,
  input wire logic in_eof_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [`INB_BIN_W-1:0] out_data_o,
  output logic out_sof_o,
  output logic out_marker_o,
  output logic blank_active_o
);
  localparam int SUMW = 24;
  localparam int MS_CYC = `INB_MS_CYCLES;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    inb_pkg::inb_state_e fsm;
    logic [3:0] sens;
    logic [6:0] dur;
    logic [7:0][SUMW-1:0] acc;
    logic [7:0][SUMW-1:0] prev;
    logic [17:0] tick;
    logic [6:0] ms_left;
    logic blanking;
    logic frame_mark;
    logic first;
    logic judged;
  } inb_core_s;
  inb_core_s st;
  inb_core_s next_st;

  // Frame buffer: a whole frame must be judged before it is forwarded
  logic [`INB_BIN_W-1:0] fbuf [512];
  logic [8:0] wr_ptr;
  logic [8:0] rd_ptr;
  logic [8:0] frame_len;
  logic draining;
  logic fifo_ready;
  logic fifo_in_valid;
  logic [`INB_BIN_W+1:0] fifo_in;
  logic [`INB_BIN_W+1:0] fifo_out;
  logic glitch;
  logic eof_take;

  function automatic logic [SUMW-1:0] slope_thr(input logic [3:0] s);
    // Higher setting, lower threshold
    slope_thr = SUMW'(5'd16 - 5'(s)) << 10;
  endfunction

  function automatic logic demod_ok(input inb_pkg::inb_demod_e d);
    demod_ok = !(d == inb_pkg::INB_ENV_AM || d == inb_pkg::INB_NFM
      || d == inb_pkg::INB_WFM);
  endfunction

  // ****************************************
  // Detection
  // ****************************************
  logic [2:0] quiet;
  logic [3:0] broad;
  always_comb begin
    quiet = 3'd0;
    broad = 4'd0;
    for (int i = 1; i < 8; i++) begin
      if (st.acc[i] < st.acc[quiet]) begin
        quiet = 3'(i);
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (st.acc[i] > st.prev[i] + slope_thr(st.sens)) begin
        broad = broad + 4'd1;
      end
    end
    glitch = (st.sens != 4'd0) && !st.first
      && (st.acc[quiet] > st.prev[quiet] + slope_thr(st.sens)) && (broad >= 4'd6);
  end

  assign in_ready_o = !draining;
  assign eof_take = in_valid_i && in_ready_o && in_eof_i;

  always_comb begin
    next_st = st;
    if (in_valid_i && in_ready_o) begin
      if (in_sof_i) begin
        next_st.sens = sens_i;
        next_st.dur = (dur_ms_i > `INB_DUR_MAX_MS) ? `INB_DUR_MAX_MS : dur_ms_i;
        for (int i = 0; i < 8; i++) begin
          next_st.acc[i] = '0;
        end
      end
      next_st.acc[in_slice_i] = (in_sof_i ? '0 : st.acc[in_slice_i]) + SUMW'(in_bin_i);
    end
    if (st.blanking) begin
      if (st.tick == 18'(MS_CYC - 1)) begin
        next_st.tick = '0;
        if (st.ms_left <= 7'd1) begin
          next_st.blanking = 1'b0;
          next_st.fsm = inb_pkg::INB_CLEAN_WAIT;
        end else begin
          next_st.ms_left = st.ms_left - 7'd1;
        end
      end else begin
        next_st.tick = st.tick + 18'd1;
      end
    end
    // Frame judged at end of frame, after the last bin is summed
    if (st.frame_mark && !draining) begin
      next_st.frame_mark = 1'b0;
    end
    if (eof_take) begin
      next_st.frame_mark = 1'b0;
    end
    // Judge each drained frame exactly once
    if (!draining) begin
      next_st.judged = 1'b0;
    end
    case (st.fsm)
      inb_pkg::INB_IDLE: begin
        if (st.frame_mark) begin
        end
      end
      inb_pkg::INB_SUBST: begin
      end
      inb_pkg::INB_CLEAN_WAIT: begin
      end
      default: next_st.fsm = inb_pkg::INB_IDLE;
    endcase
    if (draining && !st.judged) begin
      next_st.judged = 1'b1;
      // Decision for this frame, made once at drain start
      next_st.frame_mark = st.blanking
        || (glitch && st.fsm == inb_pkg::INB_IDLE && demod_ok(demod_i));
      if (glitch && st.fsm == inb_pkg::INB_IDLE && demod_ok(demod_i)
          && !st.blanking && st.dur != 7'd0) begin
        next_st.blanking = 1'b1;
        next_st.fsm = inb_pkg::INB_SUBST;
        next_st.ms_left = st.dur;
        next_st.tick = '0;
      end else if (!st.blanking && st.fsm == inb_pkg::INB_CLEAN_WAIT) begin
        next_st.fsm = inb_pkg::INB_IDLE; // real frame passes
      end
      next_st.prev = st.acc;
      next_st.first = 1'b0;
    end
  end

  // ****************************************
  // Frame store and drain
  // ****************************************
  assign fifo_in_valid = draining && st.judged;
  assign fifo_in = {rd_ptr == 9'd0, st.frame_mark,
    st.frame_mark ? `INB_MARK_CODE : fbuf[rd_ptr]};

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st.fsm <= inb_pkg::INB_IDLE;
      st.sens <= '0;
      st.dur <= '0;
      st.acc <= '0;
      st.prev <= '0;
      st.tick <= '0;
      st.ms_left <= '0;
      st.blanking <= 1'b0;
      st.frame_mark <= 1'b0;
      st.first <= 1'b1;
      st.judged <= 1'b0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      frame_len <= '0;
      draining <= 1'b0;
    end else begin
      st <= next_st;
      if (in_valid_i && in_ready_o) begin
        wr_ptr <= in_sof_i ? 9'd1 : wr_ptr + 9'd1;
        if (in_eof_i) begin
          frame_len <= in_sof_i ? 9'd1 : wr_ptr + 9'd1;
          draining <= 1'b1;
          rd_ptr <= '0;
        end
      end else if (draining && fifo_in_valid && fifo_ready) begin
        if (rd_ptr == frame_len - 9'd1) begin
          draining <= 1'b0;
        end else begin
          rd_ptr <= rd_ptr + 9'd1;
        end
      end
    end
    if (in_valid_i && in_ready_o) begin
      fbuf[in_sof_i ? 9'd0 : wr_ptr] <= in_bin_i;
    end
  end

  inb_fifo #(
    .WIDTH(`INB_BIN_W + 2),
    .DEPTH(`INB_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_ready),
    .in_data_i(fifo_in),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(fifo_out)
  );

  assign out_sof_o = fifo_out[`INB_BIN_W+1];
  assign out_marker_o = fifo_out[`INB_BIN_W];
  assign out_data_o = fifo_out[`INB_BIN_W-1:0];
  assign blank_active_o = st.blanking;
endmodule

// file: sim/inb_blanker_checker.sv
`timescale 1ns/10ps
// ************
// Port checker
// ************
module inb_blanker_checker (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] sens_i,
  input wire logic [6:0] dur_ms_i,
  input wire inb_pkg::inb_demod_e demod_i,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [15:0] out_data_o,
  input wire logic out_sof_o,
  input wire logic out_marker_o,
  input wire logic blank_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_MARK_CODE: assert property (out_valid_o && out_marker_o |-> out_data_o == 16'hFFFF)
    else $error("marker word has wrong code");
  AST_STALL: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("output word changed while stalled");
  AST_OFF: assert property ($rose(blank_active_o) |-> $past(sens_i) != 4'h0)
    else $error("blank started with sensitivity zero");
  AST_DEMOD: assert property ($rose(blank_active_o) |-> !($past(demod_i) inside
    {inb_pkg::INB_ENV_AM, inb_pkg::INB_NFM, inb_pkg::INB_WFM}))
    else $error("blank started in a barred demodulator");
  AST_DUR0: assert property ($rose(blank_active_o) |-> $past(dur_ms_i) != 7'h00)
    else $error("blank started with zero duration");
  AST_HOLD: assert property ($rose(blank_active_o) |=> blank_active_o [*8])
    else $error("blank ended too early");
  AST_RETRIG: assert property ($fell(blank_active_o) |-> !blank_active_o [*2])
    else $error("blank retriggered at once");
  AST_MARK_ACT: assert property (out_valid_o && out_sof_o && out_marker_o |-> blank_active_o)
    else $error("marker frame without blank status");
  AST_RESET: assert property (disable iff (1'b0) !resetn_i |=> !out_valid_o && !blank_active_o)
    else $error("outputs active after reset");
  COV_BLANK: cover property ($rose(blank_active_o));
  COV_MARK: cover property (out_valid_o && out_ready_i && out_marker_o);
  COV_STALL: cover property (out_valid_o && !out_ready_i);
endmodule
bind inb_blanker inb_blanker_checker u_chk(.clk_i(clk_i), .resetn_i(resetn_i), .sens_i(sens_i),
  .dur_ms_i(dur_ms_i), .demod_i(demod_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .out_data_o(out_data_o), .out_sof_o(out_sof_o), .out_marker_o(out_marker_o),
  .blank_active_o(blank_active_o));

// file: sim/inb_audio_model.sv
`timescale 1ns/10ps
// ***********
// Audio side
// ***********
module inb_audio_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic [15:0] data_i,
  input wire logic marker_i,
  output logic ready_o = 1'b1,
  output int words_o = 0,
  output int marks_o = 0,
  output logic [15:0] audio_o = 16'h0000
);
  // Stall every other cycle when slow, to load the fifo
  always @(negedge clk_i) ready_o <= slow_i ? ~ready_o : 1'b1;
  always @(posedge clk_i) begin
    if (valid_i && ready_o) begin
      words_o <= words_o + 1;
      if (marker_i) marks_o <= marks_o + 1; // Hold last clean spectrum
      else audio_o <= data_i; // Resume on first clean word
    end
  end
endmodule

// file: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] sens_i = 4'h0;
  logic [6:0] dur_ms_i = 7'h00;
  inb_pkg::inb_demod_e demod_i = inb_pkg::INB_DOUBLE_SIDEBAND;
  logic in_valid_i = 1'b0;
  logic [15:0] in_bin_i = 16'h0000;
  logic in_sof_i = 1'b0;
  logic [2:0] in_slice_i = 3'h0;
  logic in_eof_i = 1'b0;
  logic slow = 1'b0;
  logic in_ready_o, out_valid_o, out_ready_i, out_sof_o, out_marker_o, blank_active_o;
  logic [15:0] out_data_o, audio;
  int words, marks, dm;
  int miscompares = 0;
  int samples_checked = 0;
  inb_blanker dut(.clk_i(clk_i), .resetn_i(resetn_i), .sens_i(sens_i), .dur_ms_i(dur_ms_i),
    .demod_i(demod_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .in_bin_i(in_bin_i),
    .in_sof_i(in_sof_i), .in_slice_i(in_slice_i), .in_eof_i(in_eof_i), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .out_data_o(out_data_o), .out_sof_o(out_sof_o),
    .out_marker_o(out_marker_o), .blank_active_o(blank_active_o));
  inb_audio_model u_audio(.clk_i(clk_i), .slow_i(slow), .valid_i(out_valid_o),
    .data_i(out_data_o), .marker_i(out_marker_o), .ready_o(out_ready_i), .words_o(words),
    .marks_o(marks), .audio_o(audio));
  initial forever #2 clk_i = ~clk_i;
  // *******
  // Helpers
  // *******
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One bin per slice, so each slice level equals the bin value
  task frame(input logic [15:0] val);
    int w0, m0, n;
    logic rdy;
    w0 = words;
    m0 = marks;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_i);
      in_valid_i = 1'b1;
      in_bin_i = val;
      in_slice_i = 3'(i);
      in_sof_i = (i == 0);
      in_eof_i = (i == 7);
      n = 0;
      // Ready is taken before the edge, not raced against it
      do begin
        rdy = in_ready_o;
        @(posedge clk_i);
        n++;
      end while (!rdy && n < 300);
    end
    @(negedge clk_i);
    in_valid_i = 1'b0;
    while (words < w0 + 8 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      conclude();
    end
    dm = marks - m0;
  endtask
  // *********
  // Scenarios
  // *********
  task t_clean;
    frame(16'h0010);
    check(dm, 0);
    check(audio, 16'h0010);
  endtask
  task t_sens(input logic [3:0] s);
    sens_i = s;
    frame(16'h2000);
    check(dm, 0);
    frame(16'h0010);
  endtask
  task t_demod;
    sens_i = 4'hF;
    for (int d = 4; d < 7; d++) begin
      demod_i = inb_pkg::inb_demod_e'(d);
      frame(16'h2000);
      check(dm, 0);
      frame(16'h0010);
    end
  endtask
  task t_blank;
    demod_i = inb_pkg::INB_DOUBLE_SIDEBAND;
    dur_ms_i = 7'h32;
    slow = 1'b1;
    frame(16'h2000);
    check(dm, 8);
    check(blank_active_o, 1);
    check(audio, 16'h0010);
    sens_i = 4'h0;
    frame(16'h0010);
    check(dm, 8);
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    t_clean();
    t_sens(4'h0);
    t_sens(4'h1);
    t_demod();
    t_blank();
    conclude();
  end
endmodule
